// ===== verification/watchdog_and_manual_reset_bench.sv
`default_nettype none
module watchdog_and_manual_reset_bench
  import wdm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [31:0] WC [4] = '{32'h28, 32'h3c, 32'h50, 32'h64};
  localparam logic [31:0] HC [4] = '{32'h5, 32'h7, 32'h9, 32'hb};
  localparam logic [31:0] OFF_CYC = 32'h32;
  localparam logic [31:0] ON_CYC = 32'h14;

  logic clk = 1'b0;
  logic rst_b, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb, channelEnable, channelRun;
  logic [1:0] bresp, rresp, rsp;
  logic watchdogToggleIn, watchdogInputFloating, manualResetN, thresholdSenseIn;
  logic processorResetN, processorResetOe, controlRegReset, resetLine, serviceOn, pressed;
  logic [7:0] highCycles, lowCycles;
  int errorCnt = 0;
  int totalChecks = 0;
  int lowCnt = 0;
  int mark;
  int n;

  always #5ns clk = !clk;

  // Open-drain reset line with its pull-up
  assign resetLine = processorResetOe ? processorResetN : 1'b1;

  always @(posedge clk) begin
    if (!resetLine) begin
      lowCnt <= lowCnt + 1;
    end
  end

  wdm_watchdog_reset #(
    .WD_CYC_0(WC[0]), .WD_CYC_1(WC[1]), .WD_CYC_2(WC[2]), .WD_CYC_3(WC[3]),
    .HOLD_CYC_0(HC[0]), .HOLD_CYC_1(HC[1]), .HOLD_CYC_2(HC[2]), .HOLD_CYC_3(HC[3]),
    .OFF_PRESS_CYC(OFF_CYC), .ON_PRESS_CYC(ON_CYC)
  ) dut (
    .clk(clk), .rst_b(rst_b), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .watchdogToggleIn(watchdogToggleIn), .watchdogInputFloating(watchdogInputFloating),
    .manualResetN(manualResetN), .thresholdSenseIn(thresholdSenseIn), .channelEnable(channelEnable),
    .processorResetN(processorResetN), .processorResetOe(processorResetOe), .channelRun(channelRun),
    .controlRegReset(controlRegReset)
  );

  wdm_host_model host (
    .clk(clk), .serviceOn(serviceOn), .highCycles(highCycles), .lowCycles(lowCycles),
    .pressed(pressed), .watchdogToggleIn(watchdogToggleIn), .manualResetN(manualResetN)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      errorCnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic awDone;
    logic wDone;
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    awDone = 1'b0;
    wDone = 1'b0;
    while (!(awDone && wDone)) begin
      @(posedge clk);
      if (!awDone && awready === 1'b1) begin
        awDone = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wDone && wready === 1'b1) begin
        wDone = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : axiWrite

  task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axiRead

  // Counts edges until the reset line reaches lvl, expects a count in lo..hi
  task automatic waitLine(input logic lvl, input logic [31:0] lo, input logic [31:0] hi, input string what);
    logic [31:0] c;
    c = 32'h0;
    while (resetLine !== lvl && c <= hi) begin
      @(posedge clk);
      c++;
    end
    check(what, 32'(c >= lo && c <= hi), 32'h1);
  endtask : waitLine

  task automatic completeRun();
    $display("checks %0d errors %0d", totalChecks, errorCnt);
    if (errorCnt == 0 && totalChecks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : completeRun

  initial begin
    #400us;
    errorCnt++;
    completeRun();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, serviceOn, pressed, watchdogInputFloating} = 8'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hf;
    channelEnable = 4'h0;
    thresholdSenseIn = 1'b1;
    highCycles = 8'h08;
    lowCycles = 8'h3e;
    repeat (10) @(posedge clk);
    check("reset line in reset", 32'(resetLine), 32'h0);
    rst_b <= 1'b1;
    axiRead(WDM_ADDR_CTRL, rd, rsp);
    check("ctrl reset value", rd, 32'h0000000a);
    check("ctrl read resp", 32'(rsp), 32'(WDM_RESP_OKAY));
    axiRead(8'h08, rd, rsp);
    check("unmapped read resp", 32'(rsp), 32'(WDM_RESP_DECERR));
    check("unmapped read data", rd, 32'h0);
    axiWrite(8'h0c, 32'hffffffff, rsp);
    check("unmapped write resp", 32'(rsp), 32'(WDM_RESP_DECERR));
    axiWrite(WDM_ADDR_STATUS, 32'h0000001f, rsp);
    check("status write resp", 32'(rsp), 32'(WDM_RESP_OKAY));
    wstrb <= 4'he;
    axiWrite(WDM_ADDR_CTRL, 32'h0000001f, rsp);
    wstrb <= 4'hf;
    axiRead(WDM_ADDR_CTRL, rd, rsp);
    check("ctrl kept without strobe", rd, 32'h0000000a);
    repeat (30) @(posedge clk);
    check("no channel enabled", 32'(resetLine), 32'h0);
    channelEnable <= 4'h5;
    waitLine(1'b1, HC[2] - 1, HC[2] + 4, "power-up hold");
    check("channels run", 32'(channelRun), 32'h5);
    serviceOn <= 1'b1;
    mark = lowCnt;
    repeat (400) @(posedge clk);
    check("narrow pulse service", 32'(lowCnt - mark), 32'h0);
    highCycles <= 8'h32;
    lowCycles <= 8'h32;
    mark = lowCnt;
    repeat (400) @(posedge clk);
    check("both edges service", 32'(lowCnt - mark), 32'h0);
    serviceOn <= 1'b0;
    // Let the host finish its current toggle period before timing expiries
    repeat (110) @(posedge clk);
    for (int s = 0; s < 4; s++) begin
      thresholdSenseIn <= 1'b0;
      waitLine(1'b0, 0, 4, "undervoltage reset");
      axiWrite(WDM_ADDR_CTRL, 32'(s * 5), rsp);
      thresholdSenseIn <= 1'b1;
      waitLine(1'b1, HC[s] - 1, HC[s] + 4, "undervoltage hold");
      waitLine(1'b0, WC[s] - 1, WC[s] + 4, "watchdog timeout");
      waitLine(1'b1, HC[s] - 1, HC[s] + 4, "watchdog hold");
    end
    watchdogInputFloating <= 1'b1;
    axiWrite(WDM_ADDR_CTRL, 32'h0000000a, rsp);
    mark = lowCnt;
    repeat (300) @(posedge clk);
    check("floating input", 32'(lowCnt - mark), 32'h0);
    pressed <= 1'b1;
    repeat (10) @(posedge clk);
    pressed <= 1'b0;
    repeat (40) @(posedge clk);
    check("button glitch", 32'(lowCnt - mark), 32'h0);
    pressed <= 1'b1;
    waitLine(1'b0, 9, 16, "button press");
    repeat (60) @(posedge clk);
    check("button held", 32'(resetLine), 32'h0);
    pressed <= 1'b0;
    waitLine(1'b1, HC[2] - 1, HC[2] + 6, "button hold");
    axiWrite(WDM_ADDR_CTRL, 32'h0000001a, rsp);
    pressed <= 1'b1;
    n = 0;
    while (controlRegReset !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    check("long press", 32'(n >= OFF_CYC && n <= OFF_CYC + 16), 32'h1);
    repeat (3) @(posedge clk);
    check("channels off", 32'(channelRun), 32'h0);
    pressed <= 1'b0;
    repeat (5) @(posedge clk);
    axiRead(WDM_ADDR_STATUS, rd, rsp);
    check("standby flag", rd & 32'h4, 32'h4);
    pressed <= 1'b1;
    repeat (20) @(posedge clk);
    check("early restart", 32'(channelRun), 32'h0);
    repeat (20) @(posedge clk);
    check("restart", 32'(channelRun), 32'h5);
    pressed <= 1'b0;
    repeat (5) @(posedge clk);
    pressed <= 1'b1;
    repeat (OFF_CYC + 20) @(posedge clk);
    pressed <= 1'b0;
    repeat (5) @(posedge clk);
    channelEnable <= 4'h0;
    repeat (5) @(posedge clk);
    channelEnable <= 4'h5;
    repeat (5) @(posedge clk);
    check("auto restart", 32'(channelRun), 32'h5);
    axiRead(WDM_ADDR_STATUS, rd, rsp);
    check("standby cleared", rd & 32'h4, 32'h0);
    completeRun();
  end
endmodule : watchdog_and_manual_reset_bench
`default_nettype wire

// ===== verification/wdm_host_model.sv
`default_nettype none
module wdm_host_model (
  input wire logic clk,
  input wire logic serviceOn,
  input wire logic [7:0] highCycles,
  input wire logic [7:0] lowCycles,
  input wire logic pressed,
  output logic watchdogToggleIn,
  output wire logic manualResetN
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Watchdog service: high for highCycles, then low for lowCycles + 1 cycles
  // ----------------------------------------------------------------
  initial begin
    watchdogToggleIn = 1'b0;
  end

  always begin
    @(posedge clk);
    if (serviceOn) begin
      watchdogToggleIn <= 1'b1;
      repeat (highCycles) @(posedge clk);
      watchdogToggleIn <= 1'b0;
      repeat (lowCycles) @(posedge clk);
    end
  end

  // ----------------------------------------------------------------
  // Push button to ground, pull-up wins while open
  // ----------------------------------------------------------------
  assign manualResetN = !pressed;
endmodule : wdm_host_model
`default_nettype wire

// ===== verilog/wdm_pkg.sv
`default_nettype none
package wdm_pkg;
  // ----------------------------------------------------------------
  // Clock
  // ----------------------------------------------------------------
  localparam longint WDM_CLK_MHZ = 100;
  localparam longint WDM_CLK_PERIOD_NS = 10;

  // ----------------------------------------------------------------
  // Times in their own units and derived cycle counts
  // ----------------------------------------------------------------
  localparam longint WDM_WD_T0_US = 6300;
  localparam longint WDM_WD_T1_US = 102000;
  localparam longint WDM_WD_T2_US = 1600000;
  localparam longint WDM_WD_T3_US = 25600000;
  localparam logic [31:0] WDM_WD_CYC_0 = 32'(WDM_WD_T0_US * WDM_CLK_MHZ);
  localparam logic [31:0] WDM_WD_CYC_1 = 32'(WDM_WD_T1_US * WDM_CLK_MHZ);
  localparam logic [31:0] WDM_WD_CYC_2 = 32'(WDM_WD_T2_US * WDM_CLK_MHZ);
  localparam logic [31:0] WDM_WD_CYC_3 = 32'(WDM_WD_T3_US * WDM_CLK_MHZ);

  localparam longint WDM_HOLD_T0_US = 1400;
  localparam longint WDM_HOLD_T1_US = 28000;
  localparam longint WDM_HOLD_T2_US = 200000;
  localparam longint WDM_HOLD_T3_US = 1600000;
  localparam logic [31:0] WDM_HOLD_CYC_0 = 32'(WDM_HOLD_T0_US * WDM_CLK_MHZ);
  localparam logic [31:0] WDM_HOLD_CYC_1 = 32'(WDM_HOLD_T1_US * WDM_CLK_MHZ);
  localparam logic [31:0] WDM_HOLD_CYC_2 = 32'(WDM_HOLD_T2_US * WDM_CLK_MHZ);
  localparam logic [31:0] WDM_HOLD_CYC_3 = 32'(WDM_HOLD_T3_US * WDM_CLK_MHZ);

  localparam longint WDM_OFF_PRESS_US = 4000000;
  localparam longint WDM_ON_PRESS_US = 500000;
  localparam logic [31:0] WDM_OFF_PRESS_CYC = 32'(WDM_OFF_PRESS_US * WDM_CLK_MHZ);
  localparam logic [31:0] WDM_ON_PRESS_CYC = 32'(WDM_ON_PRESS_US * WDM_CLK_MHZ);

  // Pulses of this width span several samples, so no stretcher is needed
  localparam longint WDM_WDI_MIN_PULSE_NS = 80;
  localparam longint WDM_MR_GLITCH_NS = 100;
  localparam logic [7:0] WDM_MR_GLITCH_CYC =
    8'((WDM_MR_GLITCH_NS + WDM_CLK_PERIOD_NS - 1) / WDM_CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] WDM_ADDR_CTRL = 8'h00;
  localparam logic [7:0] WDM_ADDR_STATUS = 8'h04;
  localparam logic [1:0] WDM_RESP_OKAY = 2'h0;
  localparam logic [1:0] WDM_RESP_DECERR = 2'h3;
  localparam int WDM_CTRL_W = 5;
  localparam int WDM_STATUS_W = 5;

  localparam logic [1:0] WDM_WD_SEL_RST = 2'h2;
  localparam logic [1:0] WDM_HOLD_SEL_RST = 2'h2;
  localparam logic WDM_MODE_PROC = 1'b0;
  localparam logic WDM_MODE_SWITCH = 1'b1;

  typedef struct packed {
    logic mrMode;
    logic [1:0] holdSel;
    logic [1:0] wdSel;
  } wdm_ctrl_t;

  localparam wdm_ctrl_t WDM_CTRL_RST = '{mrMode: WDM_MODE_PROC, holdSel: WDM_HOLD_SEL_RST, wdSel: WDM_WD_SEL_RST};

  typedef struct packed {
    logic wdRunning;
    logic mrPressed;
    logic standby;
    logic underVoltage;
    logic resetActive;
  } wdm_status_t;

  typedef enum logic [1:0] {
    WDM_SW_ON = 2'h0,
    WDM_SW_OFF_HOLD = 2'h1,
    WDM_SW_STANDBY = 2'h3,
    WDM_SW_ON_HOLD = 2'h2
  } wdm_sw_state_t;
endpackage : wdm_pkg
`default_nettype wire

// ===== verilog/wdm_watchdog_reset.sv
`default_nettype none
module wdm_watchdog_reset
  import wdm_pkg::*;
#(
  parameter logic [31:0] WD_CYC_0 = WDM_WD_CYC_0,
  parameter logic [31:0] WD_CYC_1 = WDM_WD_CYC_1,
  parameter logic [31:0] WD_CYC_2 = WDM_WD_CYC_2,
  parameter logic [31:0] WD_CYC_3 = WDM_WD_CYC_3,
  parameter logic [31:0] HOLD_CYC_0 = WDM_HOLD_CYC_0,
  parameter logic [31:0] HOLD_CYC_1 = WDM_HOLD_CYC_1,
  parameter logic [31:0] HOLD_CYC_2 = WDM_HOLD_CYC_2,
  parameter logic [31:0] HOLD_CYC_3 = WDM_HOLD_CYC_3,
  parameter logic [31:0] OFF_PRESS_CYC = WDM_OFF_PRESS_CYC,
  parameter logic [31:0] ON_PRESS_CYC = WDM_ON_PRESS_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic watchdogToggleIn,
  input wire logic watchdogInputFloating,
  input wire logic manualResetN,
  input wire logic thresholdSenseIn,
  input wire logic [3:0] channelEnable,
  output logic processorResetN,
  output logic processorResetOe,
  output logic [3:0] channelRun,
  output logic controlRegReset
);
  // ----------------------------------------------------------------
  // Register slave
  // ----------------------------------------------------------------
  logic awHeld_q, awHeld_d, wHeld_q, wHeld_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [7:0] awAddr_q, awAddr_d;
  logic [31:0] wData_q, wData_d, rdata_q, rdata_d;
  logic [3:0] wStrb_q, wStrb_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  wdm_ctrl_t ctrl_q, ctrl_d;
  wdm_status_t status;

  assign awready = !awHeld_q && !bvalid_q;
  assign wready = !wHeld_q && !bvalid_q;
  assign arready = !rvalid_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  always_comb begin
    awHeld_d = awHeld_q;
    awAddr_d = awAddr_q;
    wHeld_d = wHeld_q;
    wData_d = wData_q;
    wStrb_d = wStrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    ctrl_d = ctrl_q;
    if (awvalid && awready) begin
      awHeld_d = 1'b1;
      awAddr_d = awaddr;
    end
    if (wvalid && wready) begin
      wHeld_d = 1'b1;
      wData_d = wdata;
      wStrb_d = wstrb;
    end
    if (awHeld_q && wHeld_q) begin
      awHeld_d = 1'b0;
      wHeld_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = WDM_RESP_OKAY;
      if (awAddr_q == WDM_ADDR_CTRL) begin
        if (wStrb_q[0]) begin
          ctrl_d = wdm_ctrl_t'(wData_q[WDM_CTRL_W-1:0]);
        end
      end else if (awAddr_q != WDM_ADDR_STATUS) begin
        bresp_d = WDM_RESP_DECERR;
      end
    end
    if (bvalid_q && bready) begin
      bvalid_d = 1'b0;
    end
    if (arvalid && arready) begin
      rvalid_d = 1'b1;
      rresp_d = WDM_RESP_OKAY;
      case (araddr)
        WDM_ADDR_CTRL: rdata_d = {{(32-WDM_CTRL_W){1'b0}}, ctrl_q};
        WDM_ADDR_STATUS: rdata_d = {{(32-WDM_STATUS_W){1'b0}}, status};
        default: begin
          rdata_d = 32'h0;
          rresp_d = WDM_RESP_DECERR;
        end
      endcase
    end
    if (rvalid_q && rready) begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      awHeld_q <= 1'b0;
      awAddr_q <= 8'h0;
      wHeld_q <= 1'b0;
      wData_q <= 32'h0;
      wStrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= WDM_RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= WDM_RESP_OKAY;
      ctrl_q <= WDM_CTRL_RST;
    end else begin
      awHeld_q <= awHeld_d;
      awAddr_q <= awAddr_d;
      wHeld_q <= wHeld_d;
      wData_q <= wData_d;
      wStrb_q <= wStrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      ctrl_q <= ctrl_d;
    end
  end

  // ----------------------------------------------------------------
  // Input synchronisers and button filter
  // ----------------------------------------------------------------
  logic wdiS1_q, wdiS2_q, wdiS3_q, mrS1_q, mrS2_q, mrPressed_q, mrPressed_d;
  logic [7:0] mrLowCnt_q, mrLowCnt_d;

  always_comb begin
    mrLowCnt_d = mrS2_q ? 8'h0 : ((mrLowCnt_q == WDM_MR_GLITCH_CYC) ? mrLowCnt_q : mrLowCnt_q + 8'h1);
    // A low of exactly the glitch span is still a glitch
    mrPressed_d = !mrS2_q && (mrLowCnt_q >= WDM_MR_GLITCH_CYC);
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wdiS1_q <= 1'b0;
      wdiS2_q <= 1'b0;
      wdiS3_q <= 1'b0;
      mrS1_q <= 1'b1;
      mrS2_q <= 1'b1;
      mrLowCnt_q <= 8'h0;
      mrPressed_q <= 1'b0;
    end else begin
      wdiS1_q <= watchdogToggleIn;
      wdiS2_q <= wdiS1_q;
      wdiS3_q <= wdiS2_q;
      mrS1_q <= manualResetN;
      mrS2_q <= mrS1_q;
      mrLowCnt_q <= mrLowCnt_d;
      mrPressed_q <= mrPressed_d;
    end
  end

  // ----------------------------------------------------------------
  // Watchdog and reset output
  // ----------------------------------------------------------------
  logic [31:0] wdCnt_q, wdCnt_d, holdCnt_q, holdCnt_d, wdLimit, holdLimit;
  logic resetOut_q, resetOut_d;
  logic supActive, underVoltage, procMrHold, srcActive, wdEdge, wdClear, wdExpire;

  assign supActive = |channelEnable;
  assign underVoltage = supActive && !thresholdSenseIn;
  assign procMrHold = (ctrl_q.mrMode == WDM_MODE_PROC) && mrPressed_q;
  assign srcActive = !supActive || underVoltage || procMrHold;
  assign wdEdge = wdiS2_q ^ wdiS3_q;
  assign wdClear = wdEdge || resetOut_q || watchdogInputFloating || underVoltage || !supActive;
  assign wdExpire = !wdClear && (wdCnt_q == wdLimit - 32'h1);

  always_comb begin
    case (ctrl_q.wdSel)
      2'h0: wdLimit = WD_CYC_0;
      2'h1: wdLimit = WD_CYC_1;
      2'h2: wdLimit = WD_CYC_2;
      default: wdLimit = WD_CYC_3;
    endcase
    case (ctrl_q.holdSel)
      2'h0: holdLimit = HOLD_CYC_0;
      2'h1: holdLimit = HOLD_CYC_1;
      2'h2: holdLimit = HOLD_CYC_2;
      default: holdLimit = HOLD_CYC_3;
    endcase
    wdCnt_d = (wdClear || wdExpire) ? 32'h0 : wdCnt_q + 32'h1;
    resetOut_d = resetOut_q;
    holdCnt_d = holdCnt_q;
    if (srcActive || wdExpire) begin
      resetOut_d = 1'b1;
      holdCnt_d = 32'h0;
    end else if (resetOut_q) begin
      if (holdCnt_q == holdLimit - 32'h1) begin
        resetOut_d = 1'b0;
        holdCnt_d = 32'h0;
      end else begin
        holdCnt_d = holdCnt_q + 32'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wdCnt_q <= 32'h0;
      holdCnt_q <= 32'h0;
      resetOut_q <= 1'b1;
    end else begin
      wdCnt_q <= wdCnt_d;
      holdCnt_q <= holdCnt_d;
      resetOut_q <= resetOut_d;
    end
  end

  assign processorResetN = !resetOut_q;
  assign processorResetOe = resetOut_q;

  // ----------------------------------------------------------------
  // Power switch mode
  // ----------------------------------------------------------------
  wdm_sw_state_t swState_q, swState_d;
  logic [31:0] pressCnt_q, pressCnt_d;
  logic [3:0] channelRun_q, channelRun_d;
  logic regClear_q, regClear_d, standby;

  assign standby = (swState_q == WDM_SW_OFF_HOLD) || (swState_q == WDM_SW_STANDBY);

  always_comb begin
    pressCnt_d = (mrPressed_q && pressCnt_q != 32'hffffffff) ? pressCnt_q + 32'h1 : 32'h0;
    if (!mrPressed_q) begin
      pressCnt_d = 32'h0;
    end
    swState_d = swState_q;
    regClear_d = 1'b0;
    case (swState_q)
      WDM_SW_ON: begin
        if ((ctrl_q.mrMode == WDM_MODE_SWITCH) && mrPressed_q && pressCnt_q == OFF_PRESS_CYC - 32'h1) begin
          swState_d = WDM_SW_OFF_HOLD;
          regClear_d = 1'b1;
        end
      end
      WDM_SW_OFF_HOLD: begin
        if (!mrPressed_q) begin
          swState_d = WDM_SW_STANDBY;
        end
      end
      WDM_SW_STANDBY: begin
        if (channelEnable == 4'h0) begin
          swState_d = WDM_SW_ON;
        end else if (mrPressed_q && pressCnt_q == ON_PRESS_CYC - 32'h1) begin
          swState_d = WDM_SW_ON_HOLD;
        end
      end
      WDM_SW_ON_HOLD: begin
        if (!mrPressed_q) begin
          swState_d = WDM_SW_ON;
        end
      end
      default: swState_d = WDM_SW_ON;
    endcase
    channelRun_d = standby ? 4'h0 : channelEnable;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      swState_q <= WDM_SW_ON;
      pressCnt_q <= 32'h0;
      channelRun_q <= 4'h0;
      regClear_q <= 1'b0;
    end else begin
      swState_q <= swState_d;
      pressCnt_q <= pressCnt_d;
      channelRun_q <= channelRun_d;
      regClear_q <= regClear_d;
    end
  end

  assign channelRun = channelRun_q;
  assign controlRegReset = regClear_q;
  assign status = '{wdRunning: !wdClear, mrPressed: mrPressed_q, standby: standby,
                    underVoltage: underVoltage, resetActive: resetOut_q};

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_wdEdgeClears;
    (wdiS2_q != wdiS3_q) |=> (wdCnt_q == 32'h0);
  endproperty
  a_wdEdgeClears: assert property (p_wdEdgeClears) else $error("watchdog edge did not clear count");

  property p_shortPulse;
    (wdiS1_q != wdiS2_q) |=> ##1 (wdCnt_q == 32'h0);
  endproperty
  a_shortPulse: assert property (p_shortPulse) else $error("sampled watchdog change lost");

  property p_expireResets;
    wdExpire |=> (!processorResetN && processorResetOe);
  endproperty
  a_expireResets: assert property (p_expireResets) else $error("timeout did not assert reset");

  property p_uvClears;
    underVoltage |=> (wdCnt_q == 32'h0) && resetOut_q;
  endproperty
  a_uvClears: assert property (p_uvClears) else $error("undervoltage did not reset and clear");

  property p_heldCleared;
    resetOut_q |=> (wdCnt_q == 32'h0);
  endproperty
  a_heldCleared: assert property (p_heldCleared) else $error("watchdog counted during reset");

  property p_floatDisables;
    watchdogInputFloating |-> !wdExpire ##1 (wdCnt_q == 32'h0);
  endproperty
  a_floatDisables: assert property (p_floatDisables) else $error("floating input did not disable watchdog");

  property p_mrGlitch;
    $fell(mrS2_q) |-> !mrPressed_q [*8];
  endproperty
  a_mrGlitch: assert property (p_mrGlitch) else $error("short button glitch accepted");

  property p_mrHold;
    procMrHold |=> !processorResetN;
  endproperty
  a_mrHold: assert property (p_mrHold) else $error("reset not asserted while button held");

  property p_holdStretch;
    ($fell(procMrHold) && !srcActive) |-> resetOut_q [*3];
  endproperty
  a_holdStretch: assert property (p_holdStretch) else $error("reset released without hold time");

  property p_offPress;
    (swState_q == WDM_SW_ON) ##1 (swState_q == WDM_SW_OFF_HOLD) |-> controlRegReset ##1 (channelRun_q == 4'h0);
  endproperty
  a_offPress: assert property (p_offPress) else $error("shutdown without clear or channel stop");

  property p_inactive;
    (channelEnable == 4'h0) |=> !processorResetN;
  endproperty
  a_inactive: assert property (p_inactive) else $error("reset released with no channel enabled");
endmodule : wdm_watchdog_reset
`default_nettype wire
